// >>> rtl/btq_timing_status.sv
// AHB-Lite register bank driving B-channel clocks, syncs and queue status
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - Interrupt polarity bit sets output level
// - Bit clock continuous or gated to B1
// - Second sync: strobe or slot envelope
// - First sync: strobe or slot envelope
// - System clock fast or 192 kHz
// - Second envelope may start half-bit early
// - Strobe timing ignores second advance bit
// - First envelope may start half-bit early
// - Strobe timing ignores first advance bit
// - Count reports bytes to first frame end
// - Overrun flag sticky until status read
// - Queue holds sixteen bytes, count shows full
module btq_timing_status
    import btq_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    output logic [31:0] HRDATA_O,
    input wire logic INT_REQ_I,
    input wire btq_rx_byte_type RX_BYTE_I,
    output logic INT_O,
    output logic BIT_CLOCK_OUT_O,
    output logic SYSTEM_CLOCK_OUT_O,
    output logic FIRST_BCHAN_SYNC_OUT_O,
    output logic SECOND_BCHAN_SYNC_OUT_O
);

    // ------------------------------------------------------------------
    // Bus address phase decode
    // ------------------------------------------------------------------
    btq_bus_state_type bus_state_reg;
    btq_bus_state_type bus_state_next;
    btq_cfg_type cfg_reg;
    btq_cfg_type cfg_next;
    logic wr_cfg_reg;
    logic ovr_reg;
    logic ovr_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [7:0] status_w;
    logic [7:0] head_w;
    logic [4:0] level_w;
    logic rx_overrun;

    wire logic ap_valid = HSEL_I && HTRANS_I[1] && HREADY_I;
    wire logic ap_read = ap_valid && !HWRITE_I;
    wire logic ap_write = ap_valid && HWRITE_I;
    wire logic hit_cfg = (HADDR_I[7:0] == ADDR_CONFIG);
    wire logic hit_status = (HADDR_I[7:0] == ADDR_STATUS);
    wire logic hit_data = (HADDR_I[7:0] == ADDR_RX_DATA);
    wire logic rd_status = ap_read && hit_status;
    wire logic rd_data = ap_read && hit_data;
    wire logic wr_cfg_now = (bus_state_reg == BUS_WRITE) && wr_cfg_reg;

    // Zero wait states, so the slave never stretches a transfer
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    assign HRDATA_O = rdata_reg;

    always_comb begin
        case (bus_state_reg)
            BUS_IDLE,
            BUS_WRITE,
            BUS_READ: begin
                if (ap_write) begin
                    bus_state_next = BUS_WRITE;
                end else if (ap_read) begin
                    bus_state_next = BUS_READ;
                end else begin
                    bus_state_next = BUS_IDLE;
                end
            end
            default: begin
                bus_state_next = BUS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    // Write data lands in the data phase; forwarding keeps a following read coherent
    assign cfg_next = wr_cfg_now ? btq_cfg_type'(HWDATA_I[7:0] & CFG_WRITE_MASK) : cfg_reg;

    assign ovr_next = rx_overrun ? 1'b1 : (rd_status ? 1'b0 : ovr_reg);

    always_comb begin
        status_w = 8'h00;
        status_w[STAT_LEVEL_MSB:0] = level_w;
        status_w[STAT_OVERRUN_BIT] = ovr_reg;
    end

    always_comb begin
        rdata_next = rdata_reg;
        if (ap_read) begin
            if (hit_cfg) begin
                rdata_next = {24'h000000, cfg_next};
            end else if (hit_status) begin
                rdata_next = {24'h000000, status_w};
            end else if (hit_data) begin
                rdata_next = {24'h000000, head_w};
            end else begin
                rdata_next = 32'h00000000;
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            bus_state_reg <= BUS_IDLE;
            wr_cfg_reg <= 1'b0;
            cfg_reg <= btq_cfg_type'(CFG_RESET);
            ovr_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            bus_state_reg <= bus_state_next;
            wr_cfg_reg <= ap_write && hit_cfg;
            cfg_reg <= cfg_next;
            ovr_reg <= ovr_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Receive queue
    // ------------------------------------------------------------------
    btq_rx_queue u_rx_queue (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .rx_i(RX_BYTE_I),
        .pop_i(rd_data),
        .head_o(head_w),
        .level_o(level_w),
        .overrun_o(rx_overrun)
    );

    // ------------------------------------------------------------------
    // Bit clock and frame position
    // ------------------------------------------------------------------
    logic [7:0] half_cnt_reg;
    logic bit_clk_reg;
    logic [5:0] bit_idx_reg;
    logic b1_gate_reg;
    wire logic bit_edge = (half_cnt_reg == BIT_HALF_LAST);
    wire logic bit_rise = bit_edge && !bit_clk_reg;
    wire logic bit_fall = bit_edge && bit_clk_reg;
    wire logic [5:0] bit_idx_next = (bit_idx_reg == FRAME_LAST_BIT) ? 6'h00 :
                                    bit_idx_reg + 6'h01;
    wire logic next_in_b1 = (bit_idx_next >= B1_SLOT_START) &&
                            (bit_idx_next < B1_SLOT_START + SLOT_BITS);

    // Gate moves only on falling edges so the gated clock never glitches
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            half_cnt_reg <= 8'h00;
            bit_clk_reg <= 1'b0;
            bit_idx_reg <= FRAME_LAST_BIT;
            b1_gate_reg <= 1'b0;
        end else begin
            half_cnt_reg <= bit_edge ? 8'h00 : half_cnt_reg + 8'h01;
            bit_clk_reg <= bit_edge ? !bit_clk_reg : bit_clk_reg;
            bit_idx_reg <= bit_rise ? bit_idx_next : bit_idx_reg;
            b1_gate_reg <= bit_fall ? next_in_b1 : b1_gate_reg;
        end
    end

    // ------------------------------------------------------------------
    // System clock
    // ------------------------------------------------------------------
    // Fast clock half period is rounded down to whole core cycles, never below one
    logic [2:0] sys_cnt_reg;
    logic sys_clk_reg;
    wire logic sys_edge = (sys_cnt_reg == SYS_HALF_LAST);

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sys_cnt_reg <= 3'h0;
            sys_clk_reg <= 1'b0;
        end else begin
            sys_cnt_reg <= sys_edge ? 3'h0 : sys_cnt_reg + 3'h1;
            sys_clk_reg <= sys_edge ? !sys_clk_reg : sys_clk_reg;
        end
    end

    // ------------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------------
    logic int_reg;
    logic bit_out_reg;
    logic sys_out_reg;
    wire logic int_next = !(INT_REQ_I ^ cfg_reg.int_pol);
    wire logic bit_out_next = cfg_reg.clock_sel ? bit_clk_reg : (bit_clk_reg && b1_gate_reg);
    wire logic sys_out_next = cfg_reg.sysclk_sel ? bit_clk_reg : sys_clk_reg;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            int_reg <= 1'b0;
            bit_out_reg <= 1'b0;
            sys_out_reg <= 1'b0;
        end else begin
            int_reg <= int_next;
            bit_out_reg <= bit_out_next;
            sys_out_reg <= sys_out_next;
        end
    end

    assign INT_O = int_reg;
    assign BIT_CLOCK_OUT_O = bit_out_reg;
    assign SYSTEM_CLOCK_OUT_O = sys_out_reg;

    // ------------------------------------------------------------------
    // Channel syncs
    // ------------------------------------------------------------------
    btq_sync_shaper #(
        .SLOT_START(B1_SLOT_START)
    ) u_first_sync (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .bit_rise_i(bit_rise),
        .bit_fall_i(bit_fall),
        .bit_idx_i(bit_idx_reg),
        .bit_idx_next_i(bit_idx_next),
        .framing_sel_i(cfg_reg.first_framing),
        .advance_i(cfg_reg.first_adv),
        .sync_o(FIRST_BCHAN_SYNC_OUT_O)
    );

    btq_sync_shaper #(
        .SLOT_START(B2_SLOT_START)
    ) u_second_sync (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .bit_rise_i(bit_rise),
        .bit_fall_i(bit_fall),
        .bit_idx_i(bit_idx_reg),
        .bit_idx_next_i(bit_idx_next),
        .framing_sel_i(cfg_reg.second_framing),
        .advance_i(cfg_reg.second_adv),
        .sync_o(SECOND_BCHAN_SYNC_OUT_O)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    a_int_polarity: assert property (##1 INT_O ==
        ($past(cfg_reg.int_pol) ? $past(INT_REQ_I) : !$past(INT_REQ_I)))
        else $error("Interrupt level does not follow polarity");
    a_bitclk_cont: assert property ($past(cfg_reg.clock_sel) |->
        BIT_CLOCK_OUT_O == $past(bit_clk_reg))
        else $error("Bit clock not continuous");
    a_bitclk_gated: assert property (!cfg_reg.clock_sel && !b1_gate_reg |=>
        !BIT_CLOCK_OUT_O)
        else $error("Gated bit clock active outside first slot");
    a_sysclk_select: assert property (##1 SYSTEM_CLOCK_OUT_O ==
        ($past(cfg_reg.sysclk_sel) ? $past(bit_clk_reg) : $past(sys_clk_reg)))
        else $error("System clock source wrong");
    a_overrun_set: assert property (rx_overrun |=> ovr_reg)
        else $error("Overrun not flagged");
    a_overrun_hold: assert property (ovr_reg && !rd_status |=> ovr_reg)
        else $error("Overrun cleared without status read");
    a_overrun_clear: assert property (rd_status && !rx_overrun |=> !ovr_reg &&
        HRDATA_O[STAT_OVERRUN_BIT] == $past(ovr_reg))
        else $error("Status read did not report and clear overrun");
    a_status_level: assert property (rd_status |=> HRDATA_O[STAT_LEVEL_MSB:0] ==
        $past(level_w))
        else $error("Status level mismatch");

    c_status_read: cover property (rd_status && ovr_reg);
    c_cfg_write: cover property (wr_cfg_now ##1 !cfg_reg.clock_sel);
    c_first_strobe: cover property ($rose(FIRST_BCHAN_SYNC_OUT_O) && cfg_reg.first_framing);
endmodule

// >>> shared/btq_pkg.sv
// Shared constants and types for the B-channel timing and queue status block
package btq_pkg;

    // ------------------------------------------------------------------
    // Clock rates and derived cycle counts
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int BIT_CLK_HZ = 192_000;
    localparam int SYS_FAST_HZ = 6_144_000;
    // Longest half period that fits, rounded down
    localparam int BIT_HALF_CYCLES = CLK_HZ / (2 * BIT_CLK_HZ);
    localparam int SYS_HALF_RAW = CLK_HZ / (2 * SYS_FAST_HZ);
    localparam int SYS_HALF_CYCLES = (SYS_HALF_RAW < 1) ? 1 : SYS_HALF_RAW;
    localparam logic [7:0] BIT_HALF_LAST = 8'(BIT_HALF_CYCLES - 1);
    localparam logic [2:0] SYS_HALF_LAST = 3'(SYS_HALF_CYCLES - 1);

    // ------------------------------------------------------------------
    // Frame layout in bit times
    // ------------------------------------------------------------------
    localparam logic [5:0] FRAME_LAST_BIT = 6'h2F;
    localparam logic [5:0] B1_SLOT_START = 6'h04;
    localparam logic [5:0] B2_SLOT_START = 6'h10;
    localparam logic [5:0] SLOT_BITS = 6'h08;

    // ------------------------------------------------------------------
    // Receive queue
    // ------------------------------------------------------------------
    localparam int QUEUE_DEPTH = 16;
    localparam logic [4:0] QUEUE_FULL_COUNT = 5'h10;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RX_DATA = 8'h08;
    localparam logic [7:0] CFG_RESET = 8'h1E;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hFE;
    localparam int STAT_OVERRUN_BIT = 5;
    localparam int STAT_LEVEL_MSB = 4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic first_adv;
        logic second_adv;
        logic sysclk_sel;
        logic first_framing;
        logic second_framing;
        logic clock_sel;
        logic int_pol;
        logic unused0;
    } btq_cfg_type;

    typedef struct packed {
        logic valid;
        logic eof;
        logic [7:0] data;
    } btq_rx_byte_type;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRITE = 3'b010,
        BUS_READ = 3'b100
    } btq_bus_state_type;

endpackage

// >>> rtl/btq_sync_shaper.sv
// Frame strobe or envelope generator for one B-channel slot
`timescale 1ns/1ps
module btq_sync_shaper
    import btq_pkg::*;
#(
    parameter logic [5:0] SLOT_START = 6'h04
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bit_rise_i,
    input wire logic bit_fall_i,
    input wire logic [5:0] bit_idx_i,
    input wire logic [5:0] bit_idx_next_i,
    input wire logic framing_sel_i,
    input wire logic advance_i,
    output logic sync_o
);
    logic sync_reg;
    logic sync_next;
    wire logic starts_slot = (bit_idx_next_i == SLOT_START);
    wire logic in_slot = (bit_idx_next_i >= SLOT_START) &&
                         (bit_idx_next_i < SLOT_START + SLOT_BITS);
    wire logic pre_slot = (bit_idx_i == SLOT_START - 6'h01);

    always_comb begin
        sync_next = sync_reg;
        if (bit_rise_i) begin
            sync_next = framing_sel_i ? starts_slot : in_slot;
        end else if (bit_fall_i && !framing_sel_i && advance_i && pre_slot) begin
            sync_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_reg <= 1'b0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_strobe_start: assert property ($rose(sync_o) && $past(framing_sel_i) |->
        $past(bit_rise_i && starts_slot))
        else $error("Strobe rose away from slot start");
    a_strobe_end: assert property (sync_o && framing_sel_i && bit_rise_i && !starts_slot
        |=> !sync_o)
        else $error("Strobe longer than one bit time");
    a_env_early: assert property (bit_fall_i && !framing_sel_i && advance_i && pre_slot
        |=> sync_o)
        else $error("Advanced envelope missed its falling edge");
    a_env_end: assert property (bit_rise_i && !framing_sel_i &&
        bit_idx_next_i == SLOT_START + SLOT_BITS |=> !sync_o)
        else $error("Envelope outlived the slot");
    c_env_advanced: cover property ($rose(sync_o) && !framing_sel_i && advance_i);
endmodule

// >>> rtl/btq_rx_queue.sv
// Sixteen-byte receive queue with end-of-frame tags and a level counted to the first frame end
`timescale 1ns/1ps
module btq_rx_queue
    import btq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire btq_rx_byte_type rx_i,
    input wire logic pop_i,
    output logic [7:0] head_o,
    output logic [4:0] level_o,
    output logic overrun_o
);
    logic [7:0] data_mem [QUEUE_DEPTH];
    logic [QUEUE_DEPTH-1:0] eof_reg;
    logic [3:0] wr_ptr_reg;
    logic [3:0] rd_ptr_reg;
    logic [4:0] count_reg;
    logic [4:0] level_w;
    logic found;
    wire logic full = (count_reg == QUEUE_FULL_COUNT);
    wire logic push = rx_i.valid && !full;
    wire logic pop = pop_i && (count_reg != 5'h00);

    // byte into a full queue dropped
    assign overrun_o = rx_i.valid && full;
    assign head_o = data_mem[rd_ptr_reg];

    // bytes up to the first frame end
    always_comb begin
        level_w = count_reg;
        found = 1'b0;
        for (int i = 0; i < QUEUE_DEPTH; i++) begin
            if (!found && (5'(i) < count_reg) && eof_reg[4'(rd_ptr_reg + 4'(i))]) begin
                level_w = 5'(i + 1);
                found = 1'b1;
            end
        end
    end
    assign level_o = level_w;

    always_ff @(posedge clk_i) begin
        if (push) begin
            data_mem[wr_ptr_reg] <= rx_i.data;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg <= 4'h0;
            rd_ptr_reg <= 4'h0;
            count_reg <= 5'h00;
            eof_reg <= '0;
        end else begin
            if (push) begin
                eof_reg[wr_ptr_reg] <= rx_i.eof;
                wr_ptr_reg <= wr_ptr_reg + 4'h1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 4'h1;
            end
            count_reg <= count_reg + {4'h0, push} - {4'h0, pop};
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_count_bound: assert property (count_reg <= QUEUE_FULL_COUNT)
        else $error("Queue count beyond depth");
    a_full_drop: assert property (rx_i.valid && full && !pop_i |=>
        count_reg == QUEUE_FULL_COUNT && $past(overrun_o))
        else $error("Byte into full queue not dropped");
    a_level_bound: assert property (level_o <= count_reg &&
        (count_reg != 5'h00 || level_o == 5'h00))
        else $error("Level out of range");
    c_queue_full: cover property (full);
endmodule

// >>> verification/btq_codec_model.sv
// Codec-side monitor measuring exported frame syncs and clocks
`timescale 1ns/1ps
module btq_codec_model (
    input wire logic clk_i,
    input wire logic bit_clk_i,
    input wire logic sys_clk_i,
    input wire logic first_sync_i,
    input wire logic second_sync_i,
    output logic [15:0] first_len_o,
    output logic [15:0] second_len_o,
    output logic [15:0] bits_per_frame_o,
    output logic [15:0] sys_period_o
);
    logic [15:0] first_run, second_run, bit_cnt, sys_cnt;
    logic bit_d, sys_d, first_d, second_d;
    wire bit_rise = bit_clk_i & ~bit_d;

    // Passive listener: a codec only samples these lines, it never drives back
    always_ff @(posedge clk_i) begin
        bit_d <= bit_clk_i;
        sys_d <= sys_clk_i;
        first_d <= first_sync_i;
        second_d <= second_sync_i;
        first_run <= first_sync_i ? first_run + 16'h1 : 16'h0;
        second_run <= second_sync_i ? second_run + 16'h1 : 16'h0;
        if (first_d && !first_sync_i) begin
            first_len_o <= first_run;
        end
        if (second_d && !second_sync_i) begin
            second_len_o <= second_run;
        end
        // Bit clock rising edges counted from one first-slot sync to the next
        if (first_sync_i && !first_d) begin
            bits_per_frame_o <= bit_cnt;
            bit_cnt <= bit_rise ? 16'h1 : 16'h0;
        end else if (bit_rise) begin
            bit_cnt <= bit_cnt + 16'h1;
        end
        if (sys_clk_i && !sys_d) begin
            sys_period_o <= sys_cnt;
            sys_cnt <= 16'h1;
        end else begin
            sys_cnt <= sys_cnt + 16'h1;
        end
    end
endmodule

// >>> verification/btq_timing_status_tb.sv
// Self-checking bench for the B-channel timing and queue status block
`timescale 1ns/1ps
module btq_timing_status_tb import btq_pkg::*;;
    localparam int BIT_T = 2 * BIT_HALF_CYCLES;
    localparam int FRAME_T = (int'(FRAME_LAST_BIT) + 1) * BIT_T;
    logic clk_i = 1'b0;
    logic rst_i, hsel, hwrite, int_req;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, rd;
    btq_rx_byte_type rx_byte;
    wire hreadyout, hresp, int_o, bit_clk, sys_clk, first_sync, second_sync;
    wire [31:0] hrdata;
    wire [15:0] first_len, second_len, bits_frame, sys_period;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;

    btq_timing_status dut (.CLK_I(clk_i), .RST_I(rst_i), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
        .HREADY_I(hreadyout), .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .HRDATA_O(hrdata),
        .INT_REQ_I(int_req), .RX_BYTE_I(rx_byte), .INT_O(int_o), .BIT_CLOCK_OUT_O(bit_clk),
        .SYSTEM_CLOCK_OUT_O(sys_clk), .FIRST_BCHAN_SYNC_OUT_O(first_sync),
        .SECOND_BCHAN_SYNC_OUT_O(second_sync));

    btq_codec_model codec (.clk_i(clk_i), .bit_clk_i(bit_clk), .sys_clk_i(sys_clk),
        .first_sync_i(first_sync), .second_sync_i(second_sync), .first_len_o(first_len),
        .second_len_o(second_len), .bits_per_frame_o(bits_frame), .sys_period_o(sys_period));

    always #10 clk_i = ~clk_i;

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Three runs of two measured frames plus bus traffic stay well below this
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Address phase held until hready, then data phase until hready again
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        @(posedge clk_i);
        while (hreadyout !== 1'b1) @(posedge clk_i);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge clk_i);
        while (hreadyout !== 1'b1) @(posedge clk_i);
        rd = hrdata;
    endtask

    task automatic push(input int n, input int eof_at, input logic [7:0] base);
        for (int i = 0; i < n; i++) begin
            rx_byte <= '{valid: 1'b1, eof: (i == eof_at), data: base + 8'(i)};
            @(posedge clk_i);
        end
        rx_byte <= '0;
    endtask

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic test_regs;
        bus(1'b0, ADDR_CONFIG, 32'h0);
        chk(rd, 32'h0000_001E);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        bus(1'b1, ADDR_CONFIG, 32'hFF);
        bus(1'b0, ADDR_CONFIG, 32'h0);
        chk(rd, 32'h0000_00FE);
        bus(1'b1, ADDR_CONFIG, 32'h1E);
        $display("test regs done");
    endtask

    task automatic test_int;
        int_req <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({31'h0, int_o}, 32'h1);
        bus(1'b1, ADDR_CONFIG, 32'h1C);
        repeat (3) @(posedge clk_i);
        chk({31'h0, int_o}, 32'h0);
        int_req <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({31'h0, int_o}, 32'h1);
        $display("test int done");
    endtask

    // Strobes with both advance bits set, continuous bit clock, fast system clock
    task automatic test_strobe;
        bus(1'b1, ADDR_CONFIG, 32'hDE);
        repeat (2 * FRAME_T + 100) @(posedge clk_i);
        chk({16'h0, first_len}, 32'(BIT_T));
        chk({16'h0, second_len}, 32'(BIT_T));
        chk({16'h0, bits_frame}, 32'(FRAME_LAST_BIT) + 32'h1);
        chk({16'h0, sys_period}, 32'(2 * SYS_HALF_CYCLES));
        $display("test strobe done");
    endtask

    // Envelopes, first one advanced, gated bit clock, slow system clock
    task automatic test_envelope;
        bus(1'b1, ADDR_CONFIG, 32'hA2);
        repeat (2 * FRAME_T + 100) @(posedge clk_i);
        chk({16'h0, first_len}, 32'(SLOT_BITS) * BIT_T + BIT_T / 2);
        chk({16'h0, second_len}, 32'(SLOT_BITS) * BIT_T);
        chk({16'h0, bits_frame}, 32'(SLOT_BITS));
        chk({16'h0, sys_period}, 32'(BIT_T));
        $display("test envelope done");
    endtask

    // Envelopes, second one advanced, continuous bit clock, slow system clock
    task automatic test_env_second;
        bus(1'b1, ADDR_CONFIG, 32'h66);
        repeat (2 * FRAME_T + 100) @(posedge clk_i);
        chk({16'h0, first_len}, 32'(SLOT_BITS) * BIT_T);
        chk({16'h0, second_len}, 32'(SLOT_BITS) * BIT_T + BIT_T / 2);
        chk({16'h0, bits_frame}, 32'(FRAME_LAST_BIT) + 32'h1);
        chk({16'h0, sys_period}, 32'(BIT_T));
        $display("test env second done");
    endtask

    task automatic test_queue;
        push(3, 1, 8'hA0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h2);
        bus(1'b0, ADDR_RX_DATA, 32'h0);
        chk(rd, 32'hA0);
        bus(1'b0, ADDR_RX_DATA, 32'h0);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h1);
        push(15, -1, 8'h10);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'(QUEUE_FULL_COUNT));
        push(1, -1, 8'hEE);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'h30);
        bus(1'b0, ADDR_STATUS, 32'h0);
        chk(rd, 32'(QUEUE_FULL_COUNT));
        bus(1'b0, ADDR_RX_DATA, 32'h0);
        chk(rd, 32'hA2);
        $display("test queue done");
    endtask

    initial begin
        rst_i = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        int_req = 1'b0;
        rx_byte = '0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        test_regs();
        test_int();
        test_strobe();
        test_envelope();
        test_env_second();
        test_queue();
        wrap_up();
    end
endmodule
